// [tb.sv]
// Purpose: Self-checking bench for the PRBS error tester
// Assumes: Every stream carries one 32-channel frame
// Notes: Count saturation needs 65535 errors and is too slow to reach
`timescale 1ns/1ps
`default_nettype none
module tb import tbt_pkg::*;;
    logic clk, rst_n, hostSel, hostWr, hostRdValid, linkClk, framePulse_n;
    logic [ADDR_W-1:0] hostAddr;
    logic [DATA_W-1:0] hostWdata, hostRdata;
    logic [NUM_STREAMS-1:0] serialInStream, serialOutStream, serialOutOe_n, flipMask;
    logic [7:0] winStart;
    logic [8:0] winLen;
    logic [3:0] txSel;
    int flipReq, txBits, txErr, frames, failures, check_count;
    tbt_ber_tester u_tbt_ber_tester (.clk, .rst_n, .hostSel, .hostWr, .hostAddr, .hostWdata,
        .hostRdata, .hostRdValid, .linkClk, .framePulse_n, .serialInStream, .serialOutStream,
        .serialOutOe_n);
    tbt_link_model u_tbt_link_model (.linkClk, .framePulse_n, .rxPins(serialInStream),
        .txPins(serialOutStream), .txOe_n(serialOutOe_n), .winStart, .winLen, .txSel, .flipMask,
        .flipReq, .txBits, .txErr, .frames);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ****
    // Shared tasks
    // ****
    task automatic print_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmp16(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmpInt(input string name, input int exp, input int got);
        check_count++;
        if (got != exp) begin
            failures++;
            $display("unexpected %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [15:0] d);
        @(posedge clk) #1;
        hostSel = 1'b1;
        hostWr = 1'b1;
        hostAddr = a;
        hostWdata = d;
        @(posedge clk) #1;
        hostSel = 1'b0;
    endtask
    task automatic chk(input string name, input logic [13:0] a, input logic [15:0] exp);
        @(posedge clk) #1;
        hostSel = 1'b1;
        hostWr = 1'b0;
        hostAddr = a;
        @(posedge clk) #1;
        hostSel = 1'b0;
        cmp16("read strobe", 16'h0001, {15'h0, hostRdValid});
        cmp16(name, exp, hostRdata);
    endtask
    task automatic waitFrames(input int n);
        int f0;
        f0 = frames;
        for (int i = 0; i < 2200 * n && frames < f0 + n; i++) @(posedge clk);
        if (frames < f0 + n) begin
            failures++;
            $display("unexpected frame count expected %0d seen %0d", f0 + n, frames);
            print_verdict();
        end
    endtask
    task automatic txMeasure(input string name, input int n, input int bits);
        int b0, e0;
        waitFrames(2);
        b0 = txBits;
        e0 = txErr;
        waitFrames(n);
        cmpInt(name, bits, txBits - b0);
        cmpInt("pattern errors", 0, txErr - e0);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        cmp16("idle data", 16'hFFFF, serialOutStream);
        cmp16("idle enables", 16'hFFFF, serialOutOe_n);
        chk("mode reset", OFF_MODE_SELECT, 16'h0000);
        chk("control reset", 14'h000F, 16'h0000);
        chk("start reset", 14'h0017, {8'h00, START_RESET});
        chk("length reset", 14'h0025, {7'h00, LENGTH_RESET});
        chk("count reset", 14'h003A, 16'h0000);
        chk("unmapped read", 14'h2000, 16'h0000);
    endtask
    task automatic t_regs();
        wr(14'h001F, 16'hFFFF);
        wr(14'h002F, 16'hFFFF);
        wr(14'h000F, 16'hFFFF);
        wr(14'h003F, 16'h1234);
        wr(OFF_MODE_SELECT, 16'hFFFF);
        chk("start field", 14'h001F, 16'h00FF);
        chk("length field", 14'h002F, 16'h01FF);
        chk("control field", 14'h000F, 16'h0001);
        chk("count read only", 14'h003F, 16'h0000);
        chk("mode field", OFF_MODE_SELECT, 16'h0030);
        wr(OFF_MODE_SELECT, 16'h0000);
        wr(14'h000F, 16'h0000);
    endtask
    task automatic t_tx();
        for (int c = 5; c < 8; c++) wr(14'h1300 + 14'(c), 16'h0005);
        wr(14'h1309, 16'h0004);
        wr(14'h130A, 16'h0003);
        txSel = 4'h3;
        wr(OFF_MODE_SELECT, 16'h0010);
        txMeasure("pattern bits", 2, 48);
        for (int c = 0; c < 32; c++) wr(14'h1000 + 14'(c), 16'h0005);
        txSel = 4'h0;
        txMeasure("full frame bits", 1, 256);
        wr(OFF_MODE_SELECT, 16'h0000);
        txMeasure("disabled bits", 1, 0);
    endtask
    task automatic t_rx();
        winStart = 8'h05;
        winLen = 9'h003;
        flipMask = 16'h0014;
        wr(14'h0012, 16'h0005);
        wr(14'h0022, 16'h0003);
        wr(14'h0014, 16'h0005);
        wr(14'h0024, 16'h0003);
        wr(OFF_MODE_SELECT, 16'h0020);
        wr(14'h0002, 16'h0001);
        waitFrames(2);
        wr(14'h0002, 16'h0003);
        waitFrames(1);
        chk("clean count", 14'h0032, 16'h0000);
        flipReq = flipReq + 5;
        waitFrames(1);
        chk("bad bits", 14'h0032, 16'h0005);
        chk("idle stream count", 14'h0034, 16'h0000);
        wr(14'h0002, 16'h0003);
        chk("cleared count", 14'h0032, 16'h0000);
        wr(OFF_MODE_SELECT, 16'h0000);
        flipReq = flipReq + 3;
        waitFrames(1);
        chk("global off count", 14'h0032, 16'h0000);
    endtask
    task automatic t_fifo();
        wr(OFF_MODE_SELECT, 16'h0020);
        @(posedge clk) #1;
        hostSel = 1'b1;
        hostWr = 1'b0;
        hostAddr = OFF_STATUS;
        // Back-to-back reads stall the sample queue until it overflows
        repeat (300) @(posedge clk);
        #1;
        hostSel = 1'b0;
        cmp16("overflow flag", 16'h0001, {15'h0, hostRdata[BIT_OVERFLOW]});
        wr(OFF_STATUS, 16'h0001);
        chk("overflow cleared", OFF_STATUS, 16'h0000);
    endtask
    initial begin
        rst_n = 1'b0;
        hostSel = 1'b0;
        hostWr = 1'b0;
        hostAddr = '0;
        hostWdata = '0;
        winStart = 8'h00;
        winLen = 9'h000;
        txSel = 4'h0;
        flipMask = '0;
        flipReq = 0;
        failures = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_tx();
        t_rx();
        t_fifo();
        print_verdict();
    end
endmodule
`default_nettype wire

// [tbt_ber_checker.sv]
// Purpose: Port assertions for the PRBS error tester
// Assumes: Link pins are slow against clk
// Notes: Bound to every tester instance
`timescale 1ns/1ps
`default_nettype none
module tbt_ber_checker import tbt_pkg::*; (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic hostSel, // Access
    input wire logic hostWr, // Write
    input wire logic [ADDR_W-1:0] hostAddr, // Address
    input wire logic [DATA_W-1:0] hostWdata, // Write data
    input wire logic [DATA_W-1:0] hostRdata, // Read data
    input wire logic hostRdValid, // Read strobe
    input wire logic linkClk, // Bit clock
    input wire logic framePulse_n, // Frame pulse
    input wire logic [NUM_STREAMS-1:0] serialInStream, // Inputs
    input wire logic [NUM_STREAMS-1:0] serialOutStream, // Outputs
    input wire logic [NUM_STREAMS-1:0] serialOutOe_n // Enables
);
    // ****
    // Helper state
    // ****
    logic rdNow, linkOld_q, txOn_q, txOn_d;
    logic [3:0] since_q, since_d;
    logic [4:0] off_q, off_d;
    assign rdNow = hostSel && !hostWr;
    always_comb begin
        txOn_d = txOn_q;
        if (hostSel && hostWr && hostAddr == OFF_MODE_SELECT) begin
            txOn_d = hostWdata[BIT_GLOBAL_TX_EN];
        end
        since_d = since_q + {3'h0, since_q != 4'hF};
        if (linkClk && !linkOld_q) begin
            since_d = 4'h0;
        end
        // Long enough for a slow link edge to flush the last pattern bit
        off_d = txOn_q ? 5'h00 : off_q + {4'h0, off_q != 5'h1F};
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            linkOld_q <= 1'b0;
            txOn_q <= 1'b0;
            since_q <= 4'hF;
            off_q <= 5'h00;
        end else begin
            linkOld_q <= linkClk;
            txOn_q <= txOn_d;
            since_q <= since_d;
            off_q <= off_d;
        end
    end
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    reset_idle_a: assert property ($rose(rst_n) |-> &serialOutOe_n && !hostRdValid)
        else $error("outputs not idle after reset");
    rd_strobe_a: assert property (rdNow |=> hostRdValid)
        else $error("read strobe missing");
    rd_cause_a: assert property (hostRdValid |-> $past(rdNow))
        else $error("read strobe without read");
    rd_hold_a: assert property (!rdNow |=> $stable(hostRdata))
        else $error("read data moved without read");
    ctrl_read_a: assert property (rdNow && hostAddr[13:4] == 10'h000
        |=> hostRdata[15:1] == 15'h0)
        else $error("control upper bits set");
    start_read_a: assert property (rdNow && hostAddr[13:4] == 10'h001
        |=> hostRdata[15:8] == 8'h00)
        else $error("start upper bits set");
    len_read_a: assert property (rdNow && hostAddr[13:4] == 10'h002
        |=> hostRdata[15:9] == 7'h00)
        else $error("length upper bits set");
    idle_high_a: assert property (&(serialOutStream | ~serialOutOe_n))
        else $error("idle output not high");
    tx_off_a: assert property (off_q == 5'h1F |-> &serialOutOe_n)
        else $error("output driven with transmit off");
    // A transmit-off write releases the pins at any time, so only enabled changes count
    slot_time_a: assert property (txOn_q && !$stable(serialOutOe_n)
        |-> since_q inside {[4'h1:4'h7]})
        else $error("output changed away from link edge");
    cover property (!(&serialOutOe_n));
    cover property (rdNow && hostAddr[13:4] == 10'h003 ##1 hostRdata != 16'h0000);
    cover property (!framePulse_n && serialInStream != 16'h0000);
endmodule
bind tbt_ber_tester tbt_ber_checker u_tbt_ber_checker (.clk, .rst_n, .hostSel, .hostWr,
    .hostAddr, .hostWdata, .hostRdata, .hostRdValid, .linkClk, .framePulse_n, .serialInStream,
    .serialOutStream, .serialOutOe_n);
`default_nettype wire

// [tbt_ber_tester.sv]
// Purpose: Per-stream PRBS transmitters and error-counting receivers
// Assumes: Link bit clock and frame pulse are slow against clk
// Notes: One data bit per rising link clock edge; 8 bits per channel
`timescale 1ns/1ps
`default_nettype none
module tbt_ber_tester import tbt_pkg::*; (
    input wire logic clk, // System clock, 125 MHz
    input wire logic rst_n, // Synchronous reset
    input wire logic hostSel, // Host access request
    input wire logic hostWr, // High for write, low for read
    input wire logic [ADDR_W-1:0] hostAddr, // Register or memory address
    input wire logic [DATA_W-1:0] hostWdata, // Write data
    output logic [DATA_W-1:0] hostRdata, // Read data
    output logic hostRdValid, // Read data strobe
    input wire logic linkClk, // TDM bit clock pin
    input wire logic framePulse_n, // TDM frame pulse pin
    input wire logic [NUM_STREAMS-1:0] serialInStream, // Serial input streams
    output logic [NUM_STREAMS-1:0] serialOutStream, // Serial output data
    output logic [NUM_STREAMS-1:0] serialOutOe_n // Output enable
);
    // ****************************************
    // Pin synchronisers and slot timing
    // ****************************************
    logic [2:0] clkSync_q;
    logic [1:0] fpSync_q;
    logic [NUM_STREAMS-1:0] dataMeta_q, dataSync_q;
    logic [BITCNT_W-1:0] bitCnt_q, bitCnt_d;
    logic bitStrobe;
    logic [CHAN_W-1:0] slotChan;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clkSync_q <= '0;
            fpSync_q <= 2'h3;
            dataMeta_q <= '0;
            dataSync_q <= '0;
        end else begin
            clkSync_q <= {clkSync_q[1:0], linkClk};
            fpSync_q <= {fpSync_q[0], framePulse_n};
            dataMeta_q <= serialInStream;
            dataSync_q <= dataMeta_q;
        end
    end

    assign bitStrobe = clkSync_q[1] && !clkSync_q[2];

    always_comb begin
        bitCnt_d = bitCnt_q;
        if (bitStrobe) begin
            bitCnt_d = fpSync_q[1] ? bitCnt_q + 1'b1 : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bitCnt_q <= '0;
        end else begin
            bitCnt_q <= bitCnt_d;
        end
    end

    assign slotChan = bitCnt_d[BITCNT_W-1:3];

    // ****************************************
    // Host decode and shared registers
    // ****************************************
    logic regAcc, cmWr, regWr;
    logic [3:0] accStream;
    logic [1:0] accKind;
    logic globalTxEn_q, globalTxEn_d, globalRxEn_q, globalRxEn_d;
    logic overflow_q, overflow_d;
    logic [DATA_W-1:0] hostRdata_d;
    logic fifoInReady, fifoOutValid, fifoOutReady, popSlot;
    tbt_slot_s fifoIn, fifoOut;

    assign regAcc = hostSel && hostAddr[13:12] == REGION_REGS;
    assign regWr = regAcc && hostWr;
    assign cmWr = hostSel && hostWr && hostAddr[13:12] == REGION_CM;
    assign accStream = hostAddr[3:0];
    assign accKind = hostAddr[5:4];

    logic [15:0] rxEn_q;
    logic [7:0] start_q [NUM_STREAMS];
    logic [8:0] length_q [NUM_STREAMS];
    logic [15:0] errors_q [NUM_STREAMS];
    logic [2:0] cmHostRd [NUM_STREAMS];

    always_comb begin
        globalTxEn_d = globalTxEn_q;
        globalRxEn_d = globalRxEn_q;
        overflow_d = overflow_q;
        if (regWr && hostAddr == OFF_MODE_SELECT) begin
            globalRxEn_d = hostWdata[BIT_GLOBAL_RX_EN];
            globalTxEn_d = hostWdata[BIT_GLOBAL_TX_EN];
        end
        // Write one to clear; a new overflow in the same cycle wins
        if (regWr && hostAddr == OFF_STATUS && hostWdata[BIT_OVERFLOW]) begin
            overflow_d = 1'b0;
        end
        if (bitStrobe && !fifoInReady) begin
            overflow_d = 1'b1;
        end
    end

    always_comb begin
        hostRdata_d = '0;
        if (hostAddr[13:12] == REGION_CM) begin
            hostRdata_d[2:0] = cmHostRd[hostAddr[11:8]];
        end else if (hostAddr == OFF_MODE_SELECT) begin
            hostRdata_d[BIT_GLOBAL_RX_EN] = globalRxEn_q;
            hostRdata_d[BIT_GLOBAL_TX_EN] = globalTxEn_q;
        end else if (hostAddr == OFF_STATUS) begin
            hostRdata_d[BIT_OVERFLOW] = overflow_q;
        end else if (hostAddr[13:6] == 8'h00) begin
            case (accKind)
                KIND_CONTROL: hostRdata_d[BIT_RX_STREAM_EN] = rxEn_q[accStream];
                KIND_START: hostRdata_d[7:0] = start_q[accStream];
                KIND_LENGTH: hostRdata_d[8:0] = length_q[accStream];
                KIND_ERRORS: hostRdata_d = errors_q[accStream];
                default: hostRdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            globalTxEn_q <= 1'b0;
            globalRxEn_q <= 1'b0;
            overflow_q <= 1'b0;
            hostRdata <= '0;
            hostRdValid <= 1'b0;
        end else begin
            globalTxEn_q <= globalTxEn_d;
            globalRxEn_q <= globalRxEn_d;
            overflow_q <= overflow_d;
            hostRdata <= (hostSel && !hostWr) ? hostRdata_d : hostRdata;
            hostRdValid <= hostSel && !hostWr;
        end
    end

    // ****************************************
    // Received slot queue
    // ****************************************
    // Host accesses stall the receivers so a clear never races a count
    assign fifoIn.bits = dataSync_q;
    assign fifoIn.chan = slotChan;
    assign fifoOutReady = !hostSel;
    assign popSlot = fifoOutValid && fifoOutReady;

    tbt_fifo #(
        .WIDTH(SLOT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_slot_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(bitStrobe),
        .inReady(fifoInReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOut)
    );

    // ****************************************
    // Per-stream transmitter and receiver
    // ****************************************
    logic [NUM_STREAMS-1:0] txBit_q, txOe_n_q;

    assign serialOutStream = txBit_q;
    assign serialOutOe_n = txOe_n_q;

    for (genvar s = 0; s < NUM_STREAMS; s++) begin : g_stream
        logic [2:0] cm [NUM_CHANS];
        logic [2:0] cmSlot;
        logic [PRBS_W-1:0] txLfsr_q, txLfsr_d, rxLfsr_q, rxLfsr_d;
        logic txBit_d, txOe_n_d, txActive, txFb;
        logic rxEn_d, clearReq, inWindow, rxRaw, mismatch;
        logic [7:0] start_d;
        logic [8:0] length_d, offset;
        logic [15:0] errors_d;
        logic [3:0] syncCnt_q, syncCnt_d;
        tbt_rx_state_e rxState_q, rxState_d;

        // Only the three pattern-related bits of each entry are held
        // Cleared on reset so no slot carries pattern before setup
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                for (int i = 0; i < NUM_CHANS; i++) begin
                    cm[i] <= '0;
                end
            end else if (cmWr && hostAddr[11:8] == s) begin
                cm[hostAddr[7:0]] <= hostWdata[2:0];
            end
        end
        assign cmHostRd[s] = cm[hostAddr[7:0]];
        assign cmSlot = cm[slotChan];

        assign txActive = globalTxEn_q && cmSlot[BIT_SPECIAL_MODE]
            && cmSlot[2:1] == PCC_PATTERN;
        assign txFb = txLfsr_q[14] ^ txLfsr_q[13];

        always_comb begin
            txLfsr_d = txLfsr_q;
            txBit_d = txBit_q[s];
            txOe_n_d = txOe_n_q[s];
            if (!globalTxEn_q) begin
                txLfsr_d = PRBS_SEED;
                txOe_n_d = 1'b1;
                txBit_d = 1'b1;
            end else if (bitStrobe) begin
                txOe_n_d = !txActive;
                txBit_d = txActive ? !txFb : 1'b1;
                if (txActive) begin
                    txLfsr_d = {txLfsr_q[13:0], txFb};
                end
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                txLfsr_q <= PRBS_SEED;
                txBit_q[s] <= 1'b1;
                txOe_n_q[s] <= 1'b1;
            end else begin
                txLfsr_q <= txLfsr_d;
                txBit_q[s] <= txBit_d;
                txOe_n_q[s] <= txOe_n_d;
            end
        end

        // Register writes for this stream
        assign clearReq = regWr && accKind == KIND_CONTROL && accStream == s
            && hostAddr[13:6] == 8'h00 && hostWdata[BIT_CLEAR_ERRORS];

        always_comb begin
            rxEn_d = rxEn_q[s];
            start_d = start_q[s];
            length_d = length_q[s];
            if (regWr && accStream == s && hostAddr[13:6] == 8'h00) begin
                case (accKind)
                    KIND_CONTROL: rxEn_d = hostWdata[BIT_RX_STREAM_EN];
                    KIND_START: start_d = hostWdata[7:0];
                    KIND_LENGTH: length_d = hostWdata[8:0];
                    default: rxEn_d = rxEn_q[s];
                endcase
            end
        end

        // Channels of a window that wrap past the frame end are not monitored
        assign offset = {1'b0, fifoOut.chan} - {1'b0, start_q[s]};
        assign inWindow = fifoOut.chan >= start_q[s] && offset < length_q[s];
        assign rxRaw = !fifoOut.bits[s];
        assign mismatch = rxRaw != (rxLfsr_q[14] ^ rxLfsr_q[13]);

        always_comb begin
            rxState_d = rxState_q;
            rxLfsr_d = rxLfsr_q;
            syncCnt_d = syncCnt_q;
            errors_d = errors_q[s];
            if (!(globalRxEn_q && rxEn_q[s])) begin
                rxState_d = RX_IDLE;
            end else begin
                case (rxState_q)
                    RX_IDLE: begin
                        rxState_d = RX_SYNC;
                        syncCnt_d = '0;
                    end
                    RX_SYNC: begin
                        // Load the local generator from the line
                        if (popSlot && inWindow) begin
                            rxLfsr_d = {rxLfsr_q[13:0], rxRaw};
                            syncCnt_d = syncCnt_q + 1'b1;
                            if (syncCnt_q == SYNC_BITS - 1'b1) begin
                                rxState_d = RX_CHECK;
                            end
                        end
                    end
                    RX_CHECK: begin
                        // Free-run on the expected bit so one line error counts once
                        if (popSlot && inWindow) begin
                            rxLfsr_d = {rxLfsr_q[13:0], rxLfsr_q[14] ^ rxLfsr_q[13]};
                            if (mismatch && errors_q[s] != ERRORS_MAX) begin
                                errors_d = errors_q[s] + 1'b1;
                            end
                        end
                    end
                    default: rxState_d = RX_IDLE;
                endcase
            end
            // Clear wins over the old count but keeps a same-cycle error
            if (clearReq) begin
                errors_d = (rxState_q == RX_CHECK && popSlot && inWindow && mismatch)
                    ? 16'h0001 : '0;
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                rxEn_q[s] <= 1'b0;
                start_q[s] <= START_RESET;
                length_q[s] <= LENGTH_RESET;
                errors_q[s] <= '0;
                rxLfsr_q <= PRBS_SEED;
                syncCnt_q <= '0;
                rxState_q <= RX_IDLE;
            end else begin
                rxEn_q[s] <= rxEn_d;
                start_q[s] <= start_d;
                length_q[s] <= length_d;
                errors_q[s] <= errors_d;
                rxLfsr_q <= rxLfsr_d;
                syncCnt_q <= syncCnt_d;
                rxState_q <= rxState_d;
            end
        end
    end
endmodule
`default_nettype wire

// [tbt_fifo.sv]
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes: Depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module tbt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset
    input wire logic inValid, // Write request
    output logic inReady, // Space available
    input wire logic [WIDTH-1:0] inData, // Write data
    output logic outValid, // Data available
    input wire logic outReady, // Consumer takes data
    output logic [WIDTH-1:0] outData // Head of queue
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic doWrite, doRead;

    assign inReady = (wrPtr_q[PW] == rdPtr_q[PW]) || (wrPtr_q[PW-1:0] != rdPtr_q[PW-1:0]);
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData = mem[rdPtr_q[PW-1:0]];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    always_comb begin
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        if (doWrite) begin
            wrPtr_d = wrPtr_q + 1'b1;
        end
        if (doRead) begin
            rdPtr_d = rdPtr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
        end
    end

    // Storage carries no reset; pointers define what is valid
    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr_q[PW-1:0]] <= inData;
        end
    end
endmodule
`default_nettype wire

// [tbt_link_model.sv]
// Purpose: Far-end TDM model: link clock, frame pulse, PRBS source and sink
// Assumes: All streams share one frame of FRAME_CH channels
// Notes: Slots outside the window carry the inverse of the last bit
`timescale 1ns/1ps
`default_nettype none
module tbt_link_model import tbt_pkg::*; #(
    parameter int FRAME_CH = 32
) (
    output var logic linkClk, // Bit clock
    output var logic framePulse_n, // Frame start
    output var logic [NUM_STREAMS-1:0] rxPins, // To receivers
    input wire logic [NUM_STREAMS-1:0] txPins, // From transmitters
    input wire logic [NUM_STREAMS-1:0] txOe_n, // Transmit enables
    input wire logic [7:0] winStart, // First sourced channel
    input wire logic [8:0] winLen, // Sourced channels
    input wire logic [3:0] txSel, // Stream checked
    input wire logic [NUM_STREAMS-1:0] flipMask, // Streams given bad bits
    input wire logic [31:0] flipReq, // Bad bits asked for
    output var int txBits, // Pattern bits seen
    output var int txErr, // Bits out of sequence
    output var int frames // Frames started
);
    logic [14:0] src, hist;
    int slot, flips;
    initial begin
        linkClk = 1'b0;
        framePulse_n = 1'b1;
        rxPins = '1;
        src = PRBS_SEED;
        hist = '0;
        slot = FRAME_CH * 8 - 1;
        flips = 0;
        txBits = 0;
        txErr = 0;
        frames = 0;
        forever begin
            #16;
            // Late in the slot, so the tester's update has landed
            if (txOe_n[txSel] === 1'b0) begin
                txBits++;
                if (!txPins[txSel] !== (hist[14] ^ hist[13])) txErr++;
                hist = {hist[13:0], !txPins[txSel]};
            end
            slot = (slot + 1) % (FRAME_CH * 8);
            framePulse_n = (slot != 0);
            frames += (slot == 0);
            if (slot >= 8 * int'(winStart) && slot < 8 * (int'(winStart) + int'(winLen))) begin
                rxPins = {NUM_STREAMS{!(src[14] ^ src[13])}};
                src = {src[13:0], src[14] ^ src[13]};
                if (flips < flipReq) begin
                    rxPins = rxPins ^ flipMask;
                    flips++;
                end
            end else begin
                rxPins = ~rxPins;
            end
            #16 linkClk = 1'b1;
            #32 linkClk = 1'b0;
        end
    end
endmodule
`default_nettype wire

// [tbt_pkg.sv]
// Purpose: Shared constants and types for the TDM PRBS bit error tester
// Assumes: Sixteen streams, up to 256 channels of 8 bits per frame
// Notes: Register and connection memory offsets are fixed here and in the tester's address decode
package tbt_pkg;
    localparam int NUM_STREAMS = 16;
    localparam int CHAN_W = 8;
    localparam int NUM_CHANS = 256;
    localparam int BITCNT_W = 11;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;
    // ****************************************
    // Host address map
    // ****************************************
    localparam logic [1:0] REGION_REGS = 2'h0;
    localparam logic [1:0] REGION_CM = 2'h1;
    localparam logic [13:0] OFF_MODE_SELECT = 14'h0100;
    localparam logic [13:0] OFF_STATUS = 14'h0101;
    localparam logic [1:0] KIND_CONTROL = 2'h0;
    localparam logic [1:0] KIND_START = 2'h1;
    localparam logic [1:0] KIND_LENGTH = 2'h2;
    localparam logic [1:0] KIND_ERRORS = 2'h3;
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int BIT_GLOBAL_RX_EN = 5;
    localparam int BIT_GLOBAL_TX_EN = 4;
    localparam int BIT_CLEAR_ERRORS = 1;
    localparam int BIT_RX_STREAM_EN = 0;
    localparam int BIT_OVERFLOW = 0;
    localparam int BIT_SPECIAL_MODE = 0;
    localparam logic [1:0] PCC_PATTERN = 2'h2;
    localparam logic [7:0] START_RESET = 8'h00;
    localparam logic [8:0] LENGTH_RESET = 9'h001;
    localparam logic [15:0] ERRORS_MAX = 16'hFFFF;
    // ****************************************
    // Pattern generator
    // ****************************************
    localparam int PRBS_W = 15;
    localparam logic [14:0] PRBS_SEED = 15'h7FFF;
    localparam logic [3:0] SYNC_BITS = 4'hF;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_SYNC = 2'b01,
        RX_CHECK = 2'b10
    } tbt_rx_state_e;

    // One sampled bit slot of all input streams
    typedef struct packed {
        logic [NUM_STREAMS-1:0] bits;
        logic [CHAN_W-1:0] chan;
    } tbt_slot_s;

    localparam int SLOT_W = $bits(tbt_slot_s);
endpackage
